/* File: core/cpk_pkg.sv */
package cpk_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int unsigned CPK_APB_AW = 8;
    localparam int unsigned CPK_WORD_W = 32;
    localparam int unsigned CPK_V14_IW = 7;
    localparam int unsigned CPK_V23_IW = 4;
    localparam int unsigned CPK_NEV = 4;
    localparam int unsigned CPK_CNT_W = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets on the APB side
    localparam logic [7:0] CPK_OFF_CTRL = 8'h00;
    localparam logic [7:0] CPK_OFF_STATUS = 8'h04;
    localparam logic [7:0] CPK_OFF_MASK = 8'h08;
    localparam logic [7:0] CPK_OFF_STATE = 8'h0c;
    localparam logic [7:0] CPK_OFF_KEYCNT = 8'h10;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned CPK_CTRL_V14 = 0;
    localparam int unsigned CPK_CTRL_V23 = 1;
    localparam int unsigned CPK_EV_V14_WR = 0;
    localparam int unsigned CPK_EV_V23_WR = 1;
    localparam int unsigned CPK_EV_V14_OFF = 2;
    localparam int unsigned CPK_EV_V23_OFF = 3;
    localparam int unsigned CPK_ST_ENC14 = 0;
    localparam int unsigned CPK_ST_ENC23 = 1;
    localparam int unsigned CPK_ST_OFF14 = 2;
    localparam int unsigned CPK_ST_OFF23 = 3;
    localparam int unsigned CPK_ST_HAS14 = 4;
    localparam int unsigned CPK_ST_HAS23 = 5;
    localparam int unsigned CPK_ST_MGMT = 6;
    localparam int unsigned CPK_CNT14_LSB = 0;
    localparam int unsigned CPK_CNT23_LSB = 16;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [1:0] CPK_CTRL_RST = 2'h0;
    localparam logic [3:0] CPK_STATUS_RST = 4'h0;
    localparam logic [3:0] CPK_MASK_RST = 4'h0;
    localparam logic [7:0] CPK_CNT_RST = 8'h00;
    localparam logic [31:0] CPK_WORD_RST = 32'h0000_0000;

    // Whole state of the control port
    typedef struct packed {
        logic [1:0] ctrl;
        logic [3:0] status;
        logic [3:0] mask;
        logic [1:0] off_prev;
        logic [7:0] cnt14;
        logic [7:0] cnt23;
        logic enc14;
        logic enc23;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [31:0] ext_word;
    } cpk_state_t;

endpackage

/* File: core/cpk_key_mem.sv */
`timescale 1ns/100ps
module cpk_key_mem #(
    parameter int unsigned AW = 4,
    parameter int unsigned DW = 32
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_index,
    input wire logic [DW-1:0] wr_word,
    input wire logic [AW-1:0] rd_index,
    output logic [DW-1:0] rd_word
);

    logic [DW-1:0] mem [2**AW];
    logic [DW-1:0] rd_word_r;

    ////////////////////////////////////////////////////////////////////////////
    // Store write, only on a strobed cycle
    // strobe gates store
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_index] <= wr_word;
        end
    end

    // Registered read, old data on a same-cycle collision
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_word_r <= '0;
        end else begin
            rd_word_r <= mem[rd_index];
        end
    end

    assign rd_word = rd_word_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_write_then_read;
        (wr_en && rd_index == wr_index) ##1 (!wr_en && rd_index == $past(wr_index));
    endsequence

    a_store_write_read: assert property (@(posedge clk) disable iff (!nrst)
        s_write_then_read |=> rd_word == $past(wr_word, 2))
        else $error("key store word not held after write");

endmodule // cpk_key_mem

/* File: core/cpk_key_port.sv */
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// Overview of operation
// - Strobed writes fill version 1.4 store
// - Strobed writes fill version 2.3 store
// - Key writes finish same cycle, no wait
// - Key port index is word address
// - 1.4 port only with management and 1.4
// - 2.3 port only with management and 2.3
// - External key input ignored under management
// - Flag shows 1.4 encryption active
// - Flag shows 2.3 encryption active
// - 1.4 off input holds engine disabled
// - 2.3 off input holds engine disabled
// - Key ports and off inputs on register clock
module cpk_key_port #(
    parameter bit KEY_MGMT_EN = 1'b1,
    parameter bit V14_EN = 1'b1,
    parameter bit V23_EN = 1'b1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [cpk_pkg::CPK_APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic v14_key_write_strobe,
    input wire logic [cpk_pkg::CPK_V14_IW-1:0] v14_key_word_index,
    input wire logic [cpk_pkg::CPK_WORD_W-1:0] v14_key_write_word,
    input wire logic v23_key_write_strobe,
    input wire logic [cpk_pkg::CPK_V23_IW-1:0] v23_key_word_index,
    input wire logic [cpk_pkg::CPK_WORD_W-1:0] v23_key_write_word,
    input wire logic [cpk_pkg::CPK_WORD_W-1:0] ext_key_word,
    input wire logic [cpk_pkg::CPK_V14_IW-1:0] v14_key_read_index,
    output logic [cpk_pkg::CPK_WORD_W-1:0] v14_key_read_word,
    input wire logic [cpk_pkg::CPK_V23_IW-1:0] v23_key_read_index,
    output logic [cpk_pkg::CPK_WORD_W-1:0] v23_key_read_word,
    input wire logic v14_engine_off,
    input wire logic v23_engine_off,
    output logic v14_encrypting_flag,
    output logic v23_encrypting_flag,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Presence of each store
    // 1.4 store presence
    localparam bit HAS14 = KEY_MGMT_EN && V14_EN;
    localparam bit HAS23 = KEY_MGMT_EN && V23_EN;

    cpk_pkg::cpk_state_t st_r;
    cpk_pkg::cpk_state_t st_nxt;

    logic wr14;
    logic wr23;
    logic apb_wr;
    logic apb_setup;
    logic [cpk_pkg::CPK_NEV-1:0] ev_set;
    logic [cpk_pkg::CPK_NEV-1:0] ev_clr;
    logic [1:0] off_now;

    ////////////////////////////////////////////////////////////////////////////
    // Event and strobe decode
    // 1.4 strobe taken
    assign wr14 = HAS14 && v14_key_write_strobe;
    assign wr23 = HAS23 && v23_key_write_strobe;
    assign off_now = {v23_engine_off, v14_engine_off};
    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && st_r.pready && pwrite;

    // Sticky events: key writes and off input changes
    always_comb begin
        ev_set = '0;
        ev_set[cpk_pkg::CPK_EV_V14_WR] = wr14;
        ev_set[cpk_pkg::CPK_EV_V23_WR] = wr23;
        ev_set[cpk_pkg::CPK_EV_V14_OFF] = off_now[0] ^ st_r.off_prev[0];
        ev_set[cpk_pkg::CPK_EV_V23_OFF] = off_now[1] ^ st_r.off_prev[1];
    end

    // Write-one-to-clear from software
    always_comb begin
        ev_clr = '0;
        if (apb_wr && paddr == cpk_pkg::CPK_OFF_STATUS) begin
            ev_clr = pwdata[cpk_pkg::CPK_NEV-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.off_prev = off_now;
        // external word used only without management
        st_nxt.ext_word = KEY_MGMT_EN ? cpk_pkg::CPK_WORD_RST : ext_key_word;

        // Control writes from software
        if (apb_wr) begin
            if (paddr == cpk_pkg::CPK_OFF_CTRL) begin
                st_nxt.ctrl = pwdata[1:0];
            end else if (paddr == cpk_pkg::CPK_OFF_MASK) begin
                st_nxt.mask = pwdata[cpk_pkg::CPK_NEV-1:0];
            end else if (paddr == cpk_pkg::CPK_OFF_KEYCNT) begin
                st_nxt.cnt14 = cpk_pkg::CPK_CNT_RST;
                st_nxt.cnt23 = cpk_pkg::CPK_CNT_RST;
            end
        end

        // Set wins over a same-cycle clear
        st_nxt.status = (st_r.status & ~ev_clr) | ev_set;

        if (wr14) begin
            st_nxt.cnt14 = st_r.cnt14 + 8'h01;
        end
        if (wr23) begin
            st_nxt.cnt23 = st_r.cnt23 + 8'h01;
        end

        st_nxt.enc14 = V14_EN && st_r.ctrl[cpk_pkg::CPK_CTRL_V14] && !v14_engine_off;
        st_nxt.enc23 = V23_EN && st_r.ctrl[cpk_pkg::CPK_CTRL_V23] && !v23_engine_off;

        // Level interrupt from unmasked sticky bits
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);

        // APB: ready raised for the access phase after setup
        st_nxt.pready = apb_setup;
        st_nxt.pslverr = 1'b0;
        st_nxt.prdata = cpk_pkg::CPK_WORD_RST;
        if (apb_setup) begin
            if (paddr == cpk_pkg::CPK_OFF_CTRL) begin
                st_nxt.prdata[1:0] = st_r.ctrl;
            end else if (paddr == cpk_pkg::CPK_OFF_STATUS) begin
                st_nxt.prdata[cpk_pkg::CPK_NEV-1:0] = st_r.status;
            end else if (paddr == cpk_pkg::CPK_OFF_MASK) begin
                st_nxt.prdata[cpk_pkg::CPK_NEV-1:0] = st_r.mask;
            end else if (paddr == cpk_pkg::CPK_OFF_STATE) begin
                st_nxt.prdata[cpk_pkg::CPK_ST_ENC14] = st_r.enc14;
                st_nxt.prdata[cpk_pkg::CPK_ST_ENC23] = st_r.enc23;
                st_nxt.prdata[cpk_pkg::CPK_ST_OFF14] = v14_engine_off;
                st_nxt.prdata[cpk_pkg::CPK_ST_OFF23] = v23_engine_off;
                st_nxt.prdata[cpk_pkg::CPK_ST_HAS14] = HAS14;
                st_nxt.prdata[cpk_pkg::CPK_ST_HAS23] = HAS23;
                st_nxt.prdata[cpk_pkg::CPK_ST_MGMT] = KEY_MGMT_EN;
            end else if (paddr == cpk_pkg::CPK_OFF_KEYCNT) begin
                st_nxt.prdata[cpk_pkg::CPK_CNT14_LSB +: cpk_pkg::CPK_CNT_W] = st_r.cnt14;
                st_nxt.prdata[cpk_pkg::CPK_CNT23_LSB +: cpk_pkg::CPK_CNT_W] = st_r.cnt23;
            end else begin
                st_nxt.pslverr = 1'b1; // Unmapped address
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    // all on the register clock
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r.ctrl <= cpk_pkg::CPK_CTRL_RST;
            st_r.status <= cpk_pkg::CPK_STATUS_RST;
            st_r.mask <= cpk_pkg::CPK_MASK_RST;
            st_r.off_prev <= 2'h0;
            st_r.cnt14 <= cpk_pkg::CPK_CNT_RST;
            st_r.cnt23 <= cpk_pkg::CPK_CNT_RST;
            st_r.enc14 <= 1'b0;
            st_r.enc23 <= 1'b0;
            st_r.irq <= 1'b0;
            st_r.pready <= 1'b0;
            st_r.pslverr <= 1'b0;
            st_r.prdata <= cpk_pkg::CPK_WORD_RST;
            st_r.ext_word <= cpk_pkg::CPK_WORD_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign v14_encrypting_flag = st_r.enc14;
    assign v23_encrypting_flag = st_r.enc23;
    assign irq = st_r.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Key stores
    // 1.4 store built only when present
    generate
        if (HAS14) begin : g_store14
            // index used directly as word address
            cpk_key_mem #(
                .AW(cpk_pkg::CPK_V14_IW),
                .DW(cpk_pkg::CPK_WORD_W)
            ) u_store14 (
                .clk(clk),
                .nrst(nrst),
                .wr_en(wr14),
                .wr_index(v14_key_word_index),
                .wr_word(v14_key_write_word),
                .rd_index(v14_key_read_index),
                .rd_word(v14_key_read_word)
            );
        end else begin : g_ext14
            assign v14_key_read_word = st_r.ext_word;
        end
    endgenerate

    // 2.3 store built only when present
    generate
        if (HAS23) begin : g_store23
            // index used directly as word address
            cpk_key_mem #(
                .AW(cpk_pkg::CPK_V23_IW),
                .DW(cpk_pkg::CPK_WORD_W)
            ) u_store23 (
                .clk(clk),
                .nrst(nrst),
                .wr_en(wr23),
                .wr_index(v23_key_word_index),
                .wr_word(v23_key_write_word),
                .rd_index(v23_key_read_index),
                .rd_word(v23_key_read_word)
            );
        end else begin : g_ext23
            assign v23_key_read_word = st_r.ext_word;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_apb_setup;
        psel && !penable;
    endsequence

    sequence s_apb_access;
        psel && penable && pready;
    endsequence

    sequence s_apb_transfer;
        s_apb_setup ##1 s_apb_access;
    endsequence

    a_v14_off_holds: assert property (v14_engine_off |=> !v14_encrypting_flag)
        else $error("1.4 flag high while off input high");

    a_v23_off_holds: assert property (v23_engine_off |=> !v23_encrypting_flag)
        else $error("2.3 flag high while off input high");

    a_v14_flag_cause: assert property (
        $rose(v14_encrypting_flag) |-> $past(st_r.ctrl[cpk_pkg::CPK_CTRL_V14] && !v14_engine_off))
        else $error("1.4 flag rose without request");

    a_v23_flag_cause: assert property (
        $rose(v23_encrypting_flag) |-> $past(st_r.ctrl[cpk_pkg::CPK_CTRL_V23] && !v23_engine_off))
        else $error("2.3 flag rose without request");

    a_v14_write_seen: assert property (
        v14_key_write_strobe && HAS14 |=> st_r.status[cpk_pkg::CPK_EV_V14_WR]
            && st_r.cnt14 == $past(st_r.cnt14) + 8'h01 || $past(apb_wr))
        else $error("1.4 key write not recorded");

    a_v23_write_seen: assert property (
        v23_key_write_strobe && HAS23 |=> st_r.status[cpk_pkg::CPK_EV_V23_WR]
            && st_r.cnt23 == $past(st_r.cnt23) + 8'h01 || $past(apb_wr))
        else $error("2.3 key write not recorded");

    a_apb_one_wait: assert property (s_apb_setup |=> pready ##1 !pready)
        else $error("APB answer not exactly one cycle after setup");

    a_irq_masked: assert property ((st_r.status & st_r.mask) == '0 |-> !irq)
        else $error("interrupt high with nothing unmasked");

    a_status_sticky: assert property (
        st_r.status[cpk_pkg::CPK_EV_V14_WR] && !apb_wr |=> st_r.status[cpk_pkg::CPK_EV_V14_WR])
        else $error("sticky bit lost without clear");

    a_v23_status_sticky: assert property (
        st_r.status[cpk_pkg::CPK_EV_V23_WR] && !apb_wr |=> st_r.status[cpk_pkg::CPK_EV_V23_WR])
        else $error("2.3 sticky bit lost without clear");

    a_off_change_event: assert property (
        $changed(v14_engine_off) |=> st_r.status[cpk_pkg::CPK_EV_V14_OFF])
        else $error("off change not flagged");

    a_v23_off_event: assert property (
        $changed(v23_engine_off) |=> st_r.status[cpk_pkg::CPK_EV_V23_OFF])
        else $error("2.3 off change not flagged");

    a_v14_flag_on: assert property (
        V14_EN && st_r.ctrl[cpk_pkg::CPK_CTRL_V14] && !v14_engine_off |=> v14_encrypting_flag)
        else $error("1.4 flag low while requested");

    a_v23_flag_on: assert property (
        V23_EN && st_r.ctrl[cpk_pkg::CPK_CTRL_V23] && !v23_engine_off |=> v23_encrypting_flag)
        else $error("2.3 flag low while requested");

    a_v14_count_hold: assert property (
        !wr14 && !(apb_wr && paddr == cpk_pkg::CPK_OFF_KEYCNT)
            |=> st_r.cnt14 == $past(st_r.cnt14))
        else $error("1.4 count moved without write");

    a_v23_count_hold: assert property (
        !wr23 && !(apb_wr && paddr == cpk_pkg::CPK_OFF_KEYCNT)
            |=> st_r.cnt23 == $past(st_r.cnt23))
        else $error("2.3 count moved without write");

    a_key_cnt_clear: assert property (
        apb_wr && paddr == cpk_pkg::CPK_OFF_KEYCNT && !wr23 |=> st_r.cnt23 == cpk_pkg::CPK_CNT_RST)
        else $error("key count not cleared by write");

    a_ctrl_write_lands: assert property (
        apb_wr && paddr == cpk_pkg::CPK_OFF_CTRL |=> st_r.ctrl == $past(pwdata[1:0]))
        else $error("control write not applied");

    a_mask_write_lands: assert property (
        apb_wr && paddr == cpk_pkg::CPK_OFF_MASK |=> st_r.mask == $past(pwdata[cpk_pkg::CPK_NEV-1:0]))
        else $error("mask write not applied");

    a_apb_access_end: assert property (s_apb_transfer |=> !pready && !pslverr)
        else $error("APB answer held past access");

    a_slverr_ready: assert property (pslverr |-> pready)
        else $error("error response without ready");

    a_rdata_idle: assert property (!pready |-> prdata == cpk_pkg::CPK_WORD_RST)
        else $error("read data driven outside access");

    a_irq_raised: assert property ((st_r.status & st_r.mask) != '0 |-> irq)
        else $error("unmasked status without interrupt");

endmodule // cpk_key_port

/* File: test/cpk_key_writer.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Key-management controller model on the two key write ports
module cpk_key_writer (
    input wire logic clk,
    input wire logic go,
    input wire logic ver,
    input wire logic [8:0] byte_addr,
    input wire logic [31:0] word,
    output logic v14_key_write_strobe,
    output logic [6:0] v14_key_word_index,
    output logic [31:0] v14_key_write_word,
    output logic v23_key_write_strobe,
    output logic [3:0] v23_key_word_index,
    output logic [31:0] v23_key_write_word
);
    // Quiet ports at time zero
    initial begin
        v14_key_write_strobe = 1'h0;
        v23_key_write_strobe = 1'h0;
        v14_key_word_index = 7'h00;
        v23_key_word_index = 4'h0;
        v14_key_write_word = 32'h0;
        v23_key_write_word = 32'h0;
    end

    // One word per request; idle lines toggle so stale data is never trusted
    always @(posedge clk) begin
        v14_key_write_strobe <= go & ~ver;
        v23_key_write_strobe <= go & ver;
        if (go) begin
            v14_key_word_index <= byte_addr[8:2];
            v23_key_word_index <= byte_addr[5:2];
            v14_key_write_word <= word;
            v23_key_write_word <= word;
        end else begin
            v14_key_word_index <= ~v14_key_word_index;
            v23_key_word_index <= ~v23_key_word_index;
            v14_key_write_word <= ~v14_key_write_word;
            v23_key_write_word <= ~v23_key_write_word;
        end
    end
endmodule // cpk_key_writer

/* File: test/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, go = 1'h0, ver = 1'h0;
    logic off14 = 1'h0, off23 = 1'h0, pready, pslverr, irq, f14, f23, se;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, ext_key_word = 32'h0, wd = 32'h0, prdata, rd, rw14, rw23;
    logic [8:0] ba = 9'h000;
    logic [6:0] ri14 = 7'h00;
    logic [3:0] ri23 = 4'h0;
    logic s14, s23;
    logic [6:0] i14;
    logic [3:0] i23;
    logic [31:0] w14, w23;
    int seed = 32'h6d859f84;
    int error_cnt = 0;
    int compares = 0;
    // Behavioural model of store, counts and sticky status
    logic [31:0] m14 [int];
    logic [31:0] m23 [int];
    int c14 = 0, c23 = 0;
    logic [3:0] mst = 4'h0;

    always #50 clk = ~clk;
    // Random external key data that must be ignored
    always @(posedge clk) ext_key_word <= $random(seed);

    cpk_key_writer ctl (.clk(clk), .go(go), .ver(ver), .byte_addr(ba), .word(wd),
        .v14_key_write_strobe(s14), .v14_key_word_index(i14), .v14_key_write_word(w14),
        .v23_key_write_strobe(s23), .v23_key_word_index(i23), .v23_key_write_word(w23));

    cpk_key_port dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .v14_key_write_strobe(s14), .v14_key_word_index(i14), .v14_key_write_word(w14),
        .v23_key_write_strobe(s23), .v23_key_word_index(i23), .v23_key_write_word(w23),
        .ext_key_word(ext_key_word), .v14_key_read_index(ri14), .v14_key_read_word(rw14),
        .v23_key_read_index(ri23), .v23_key_read_word(rw23), .v14_engine_off(off14),
        .v23_engine_off(off23), .v14_encrypting_flag(f14), .v23_encrypting_flag(f23), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("Compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'h1) break;
        end
        rd = prdata;
        se = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (i == 20) begin
            error_cnt++;
            conclude();
        end
    endtask

    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(n, e, rd);
    endtask

    // Request one key word; the model takes it at once
    task automatic kw(input logic v, input logic [8:0] b, input logic [31:0] d);
        @(posedge clk);
        go <= 1'h1;
        ver <= v;
        ba <= b;
        wd <= d;
        if (v) m23[b[5:2]] = d;
        else m14[b[8:2]] = d;
        if (v) c23++;
        else c14++;
        mst |= v ? 4'h2 : 4'h1;
    endtask

    // Engine reads of every written word, one cycle latency
    task automatic readback;
        foreach (m14[i]) begin
            @(posedge clk);
            ri14 <= i[6:0];
            @(posedge clk);
            #1 chk("v14 key", m14[i], rw14);
        end
        foreach (m23[i]) begin
            @(posedge clk);
            ri23 <= i[3:0];
            @(posedge clk);
            #1 chk("v23 key", m23[i], rw23);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog on the whole run
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        conclude();
    end

    initial begin
        logic [31:0] r;
        repeat (3) @(posedge clk);
        nrst <= 1'h1;
        rdchk("state", cpk_pkg::CPK_OFF_STATE, 32'h70);
        rdchk("keycnt", cpk_pkg::CPK_OFF_KEYCNT, 32'h0);
        // Back-to-back random key words on both ports
        for (int n = 0; n < 40; n++) begin
            r = $random(seed);
            kw(r[7], {r[6:0], 2'h0}, $random(seed));
            // Read index set with the request, one cycle ahead of the store's write index
            ri14 <= r[6:0];
            ri23 <= r[3:0];
        end
        @(posedge clk);
        go <= 1'h0;
        repeat (4) @(posedge clk);
        readback();
        rdchk("keycnt", cpk_pkg::CPK_OFF_KEYCNT, {8'h0, c23[7:0], 8'h0, c14[7:0]});
        rdchk("status", cpk_pkg::CPK_OFF_STATUS, {28'h0, mst});
        // Interrupt raised, masked and cleared
        chk("irq masked", 32'h0, {31'h0, irq});
        for (int k = 0; k < 2; k++) begin
            apb(1'h1, cpk_pkg::CPK_OFF_MASK, 32'h1 << k);
            repeat (2) @(posedge clk);
            chk("irq set", {31'h0, mst[k]}, {31'h0, irq});
            apb(1'h1, cpk_pkg::CPK_OFF_STATUS, 32'h1 << k);
            mst[k] = 1'h0;
            repeat (2) @(posedge clk);
            chk("irq clear", 32'h0, {31'h0, irq});
        end
        apb(1'h1, cpk_pkg::CPK_OFF_KEYCNT, 32'h0);
        rdchk("keycnt clr", cpk_pkg::CPK_OFF_KEYCNT, 32'h0);
        // Encryption flags and off inputs
        apb(1'h1, cpk_pkg::CPK_OFF_CTRL, 32'h3);
        repeat (2) @(posedge clk);
        chk("flags", 32'h3, {30'h0, f23, f14});
        off14 <= 1'h1;
        repeat (3) @(posedge clk);
        chk("flags off14", 32'h2, {30'h0, f23, f14});
        off23 <= 1'h1;
        repeat (3) @(posedge clk);
        chk("flags off23", 32'h0, {30'h0, f23, f14});
        rdchk("state off", cpk_pkg::CPK_OFF_STATE, 32'h7c);
        rdchk("status off", cpk_pkg::CPK_OFF_STATUS, 32'hc);
        off14 <= 1'h0;
        off23 <= 1'h0;
        apb(1'h1, cpk_pkg::CPK_OFF_CTRL, 32'h1);
        repeat (2) @(posedge clk);
        chk("flag 1.4 only", 32'h1, {30'h0, f23, f14});
        // key port reset after toggling the off inputs
        nrst <= 1'h0;
        repeat (2) @(posedge clk);
        nrst <= 1'h1;
        chk("flags reset", 32'h0, {30'h0, f23, f14});
        rdchk("ctrl reset", cpk_pkg::CPK_OFF_CTRL, 32'h0);
        readback();
        // Unmapped addresses refused
        apb(1'h1, 8'h14, 32'hffff_ffff);
        chk("slverr wr", 32'h1, {31'h0, se});
        apb(1'h0, 8'hfc, 32'h0);
        chk("slverr rd", 32'h1, {31'h0, se});
        chk("unmapped data", 32'h0, rd);
        conclude();
    end
endmodule // tb_top
